// File: verilog/mcu_timing_consts.vh
`ifndef MCU_TIMING_CONSTS_VH
`define MCU_TIMING_CONSTS_VH

// Opcodes that the sequencer executes itself
`define OP_NOP 8'h00
`define OP_LJMP 8'h02
`define OP_JBC 8'h10
`define OP_JB 8'h20
`define OP_ADD_IMM 8'h24
`define OP_RLC 8'h33
`define OP_JC 8'h40
`define OP_JNC 8'h50
`define OP_ANL_DIR_IMM 8'h53
`define OP_JZ 8'h60
`define OP_JNZ 8'h70
`define OP_JMP_INDEXED 8'h73
`define OP_MOV_A_IMM 8'h74
`define OP_SJMP 8'h80
`define OP_MOV_DIR_DIR 8'h85
`define OP_MOV_POINTER_IMM 8'h90
`define OP_MOVC_INDEXED 8'h93
`define OP_INC_POINTER 8'ha3
`define OP_CJNE_A_IMM 8'hb4
`define OP_PUSH 8'hc0
`define OP_SWAP 8'hc4
`define OP_POP 8'hd0
`define OP_DJNZ_DIR 8'hd5
`define OP_MOVX_RD 8'he0
`define OP_CLR_A 8'he4
`define OP_MOVX_WR 8'hf0

// Length and cycle count packed as {len[1:0], cycles[2:0]}
`define T_ADD_IMM {2'd2, 3'd2}
`define T_ADD_RN {2'd1, 3'd1}
`define T_CJNE_IND {2'd3, 3'd5}
`define T_CJNE_A_IMM {2'd3, 3'd4}
`define T_DJNZ_DIR {2'd3, 3'd5}
`define T_DJNZ_RN {2'd2, 3'd4}
`define T_JB {2'd3, 3'd5}
`define T_JBC {2'd3, 3'd5}
`define T_JC_JNC {2'd2, 3'd3}
`define T_JZ_JNZ {2'd2, 3'd4}
`define T_JMP_INDEXED {2'd1, 3'd5}
`define T_MOVC_INDEXED {2'd1, 3'd5}
`define T_MOVX_WR {2'd1, 3'd1}
`define T_MOVX_RD {2'd1, 3'd2}
`define T_MOV_POINTER {2'd3, 3'd3}
`define T_PUSH {2'd2, 3'd3}
`define T_POP {2'd2, 3'd2}
`define T_MOV_DIR_DIR {2'd3, 3'd3}
`define T_ANL_DIR_IMM {2'd3, 3'd3}
`define T_SWAP {2'd1, 3'd1}
`define T_RLC {2'd1, 3'd1}

// Reset values and memory map
`define RST_PC 16'h0000
`define RST_SP 8'h07
`define RST_POINTER 16'h0000
`define BIT_AREA_HI 3'b010
`define SFR_ACC 8'he0
`define SFR_SP 8'h81
`define SFR_DPL0 8'h82
`define SFR_DPH0 8'h83
`define SFR_DPL1 8'h84
`define SFR_DPH1 8'h85

`endif

// File: verilog/opcode_timing.v
`timescale 1ns/1ps
`include "mcu_timing_consts.vh"

module opcode_timing (
  input wire [7:0] opcode,
  output reg [1:0] len,
  output reg [2:0] cycles
);

  reg [4:0] lc;
  reg [4:0] rn_lc;
  reg [4:0] ri_lc;

  // Register-operand group, selected by the high nibble
  always @* begin
    case (opcode[7:4])
      4'h0: rn_lc = {2'd1, 3'd2};
      4'h1: rn_lc = {2'd1, 3'd2};
      4'h2: rn_lc = `T_ADD_RN;
      4'h7: rn_lc = {2'd2, 3'd2};
      4'h8: rn_lc = {2'd2, 3'd2};
      4'ha: rn_lc = {2'd2, 3'd3};
      4'hb: rn_lc = {2'd3, 3'd4};
      4'hc: rn_lc = {2'd1, 3'd2};
      4'hd: rn_lc = `T_DJNZ_RN;
      default: rn_lc = {2'd1, 3'd1};
    endcase
  end

  // Indirect-operand group, selected by the high nibble
  always @* begin
    case (opcode[7:4])
      4'h0: ri_lc = {2'd1, 3'd3};
      4'h1: ri_lc = {2'd1, 3'd3};
      4'h7: ri_lc = {2'd2, 3'd2};
      4'h8: ri_lc = {2'd2, 3'd3};
      4'ha: ri_lc = {2'd2, 3'd3};
      4'hb: ri_lc = `T_CJNE_IND;
      4'hc: ri_lc = {2'd1, 3'd3};
      4'hd: ri_lc = {2'd1, 3'd3};
      default: ri_lc = {2'd1, 3'd2};
    endcase
  end

  // Length and cycle table, counted in system clocks
  always @* begin
    casez (opcode)
      8'b???0_0001: lc = {2'd2, 3'd3};
      8'b???1_0001: lc = {2'd2, 3'd4};
      8'b????_1???: lc = rn_lc;
      8'b????_011?: lc = ri_lc;
      8'h02: lc = {2'd3, 3'd4};
      8'h05: lc = {2'd2, 3'd3};
      8'h10: lc = `T_JBC;
      8'h12: lc = {2'd3, 3'd4};
      8'h15: lc = {2'd2, 3'd3};
      8'h20: lc = `T_JB;
      8'h22: lc = {2'd1, 3'd4};
      8'h24: lc = `T_ADD_IMM;
      8'h25: lc = {2'd2, 3'd2};
      8'h30: lc = {2'd3, 3'd5};
      8'h32: lc = {2'd1, 3'd4};
      8'h33: lc = `T_RLC;
      8'h34: lc = {2'd2, 3'd2};
      8'h35: lc = {2'd2, 3'd2};
      8'h40: lc = `T_JC_JNC;
      8'h50: lc = `T_JC_JNC;
      8'h53: lc = `T_ANL_DIR_IMM;
      8'h60: lc = `T_JZ_JNZ;
      8'h70: lc = `T_JZ_JNZ;
      8'h73: lc = `T_JMP_INDEXED;
      8'h75: lc = {2'd3, 3'd3};
      8'h80: lc = {2'd2, 3'd3};
      8'h83: lc = {2'd1, 3'd4};
      8'h84: lc = {2'd1, 3'd6};
      8'h85: lc = `T_MOV_DIR_DIR;
      8'h90: lc = `T_MOV_POINTER;
      8'h92: lc = {2'd2, 3'd3};
      8'h93: lc = `T_MOVC_INDEXED;
      8'ha3: lc = {2'd1, 3'd1};
      8'ha4: lc = {2'd1, 3'd2};
      8'ha5: lc = {2'd1, 3'd1};
      8'hb2: lc = {2'd2, 3'd3};
      8'hb3: lc = {2'd1, 3'd1};
      8'hb4: lc = `T_CJNE_A_IMM;
      8'hb5: lc = {2'd3, 3'd5};
      8'hc0: lc = `T_PUSH;
      8'hc2: lc = {2'd2, 3'd3};
      8'hc3: lc = {2'd1, 3'd1};
      8'hc4: lc = `T_SWAP;
      8'hc5: lc = {2'd2, 3'd3};
      8'hd0: lc = `T_POP;
      8'hd2: lc = {2'd2, 3'd3};
      8'hd3: lc = {2'd1, 3'd1};
      8'hd4: lc = {2'd1, 3'd3};
      8'hd5: lc = `T_DJNZ_DIR;
      8'he0: lc = `T_MOVX_RD;
      8'he2, 8'he3: lc = {2'd1, 3'd2};
      8'he5: lc = {2'd2, 3'd2};
      8'hf0: lc = `T_MOVX_WR;
      8'hf2, 8'hf3: lc = {2'd1, 3'd1};
      8'hf5: lc = {2'd2, 3'd2};
      8'h00, 8'h03, 8'h04, 8'h13, 8'h14, 8'h23, 8'he4, 8'hf4: lc = {2'd1, 3'd1};
      8'h72, 8'h82, 8'ha2: lc = {2'd2, 3'd2};
      8'h?2: lc = {2'd2, 3'd3};
      8'h?3: lc = {2'd3, 3'd3};
      8'h?4: lc = {2'd2, 3'd2};
      8'h?5: lc = {2'd2, 3'd2};
      8'h?0: lc = {2'd2, 3'd2};
      default: lc = {2'd1, 3'd1};
    endcase
  end

  // Unpack
  always @* begin
    len = lc[4:3];
    cycles = lc[2:0];
  end

endmodule // opcode_timing

// File: verilog/instr_sequencer.v
`timescale 1ns/1ps
`include "mcu_timing_consts.vh"

module instr_sequencer (
  input wire clk,
  input wire rst_n,
  output wire [15:0] code_addr,
  input wire [7:0] code_data,
  input wire data_pointer_select,
  output reg [15:0] xram_addr_reg,
  output reg [7:0] xram_wdata_reg,
  output reg xram_we_reg,
  output reg xram_re_reg,
  input wire [7:0] xram_rdata,
  output reg [15:0] pc_reg,
  output reg [7:0] acc_reg,
  output reg cy_reg,
  output reg [15:0] pointer0_reg,
  output reg [15:0] pointer1_reg,
  output reg instr_done_reg,
  output reg [7:0] last_opcode_reg
);

  // Length and cycles of the indexed code read
  localparam [4:0] MOVC_LC = `T_MOVC_INDEXED;
  reg [2:0] cnt_reg;
  reg [7:0] opc_reg;
  reg [7:0] op1_reg;
  reg [7:0] op2_reg;
  reg [7:0] sp_reg;
  reg [7:0] iram [0:127];

  reg [15:0] pc_next;
  reg [7:0] acc_next;
  reg cy_next;
  reg [7:0] sp_next;
  reg [15:0] d0_next;
  reg [15:0] d1_next;
  reg [15:0] xaddr_next;
  reg [7:0] xwdata_next;
  reg xwe_next;
  reg xre_next;
  reg we;
  reg [7:0] wa;
  reg [7:0] wd;
  reg load_pointer;
  reg [15:0] pointer_new;
  reg [8:0] sum;
  reg [7:0] dec;
  reg [7:0] dir1;
  reg [7:0] sp_inc;

  wire [1:0] len;
  wire [2:0] cyc;

  // Opcode and operands: live from code memory in their fetch cycle, held after
  wire [7:0] opc = (cnt_reg == 3'd0) ? code_data : opc_reg;
  wire [7:0] b1 = (cnt_reg == 3'd1) ? code_data : op1_reg;
  wire [7:0] b2 = (cnt_reg == 3'd2) ? code_data : op2_reg;
  wire exec = (cnt_reg == (cyc - 3'd1));
  wire [15:0] active_data_pointer = data_pointer_select ? pointer1_reg : pointer0_reg;
  wire [15:0] acc_plus_pointer = {8'h00, acc_reg} + active_data_pointer;
  wire [15:0] pc_seq = pc_reg + {14'h0000, len};
  wire [7:0] rn = iram[{4'h0, opc[2:0]}];
  wire [7:0] ri = iram[{6'h00, opc[0]}];
  wire [7:0] ind = iram[ri[6:0]];
  wire [7:0] stk = iram[sp_reg[6:0]];
  wire [7:0] bit_byte = iram[{`BIT_AREA_HI, b1[6:3]}];
  wire bit_val = ~b1[7] & bit_byte[b1[2:0]];

  // Sign-extended relative branch target
  function [15:0] rel_tgt;
    input [15:0] base;
    input [7:0] r;
    begin
      rel_tgt = base + {{8{r[7]}}, r};
    end
  endfunction

  // Length and cycle count of the current opcode
  opcode_timing u_timing (
    .opcode(opc),
    .len(len),
    .cycles(cyc)
  );

  // Operand bytes follow the opcode; indexed read in the last cycle, held opcode avoids a memory loop
  assign code_addr = (opc_reg == `OP_MOVC_INDEXED && cnt_reg == MOVC_LC[2:0] - 3'd1) ?
                     acc_plus_pointer : pc_reg + {13'h0000, cnt_reg};

  // Direct-address read of the first operand, with a few core SFRs
  always @* begin
    dir1 = 8'h00;
    if (!b1[7]) begin
      dir1 = iram[b1[6:0]];
    end else begin
      case (b1)
        `SFR_ACC: dir1 = acc_reg;
        `SFR_SP: dir1 = sp_reg;
        `SFR_DPL0: dir1 = pointer0_reg[7:0];
        `SFR_DPH0: dir1 = pointer0_reg[15:8];
        `SFR_DPL1: dir1 = pointer1_reg[7:0];
        `SFR_DPH1: dir1 = pointer1_reg[15:8];
        default: dir1 = 8'h00;
      endcase
    end
  end

  // Execute stage: all effects except the external read request land in the last cycle of the instruction
  always @* begin
    pc_next = pc_reg;
    acc_next = acc_reg;
    cy_next = cy_reg;
    sp_next = sp_reg;
    d0_next = pointer0_reg;
    d1_next = pointer1_reg;
    xaddr_next = xram_addr_reg;
    xwdata_next = xram_wdata_reg;
    xwe_next = 1'b0;
    xre_next = 1'b0;
    we = 1'b0;
    wa = 8'h00;
    wd = 8'h00;
    load_pointer = 1'b0;
    pointer_new = active_data_pointer;
    sum = 9'h000;
    dec = 8'h00;
    sp_inc = sp_reg + 8'h01;
    // External read address goes out one cycle ahead of the capture
    if (opc == `OP_MOVX_RD && cnt_reg == 3'd0) begin
      xaddr_next = active_data_pointer;
      xre_next = 1'b1;
    end
    if (exec) begin
      pc_next = pc_seq;
      casez (opc)
        `OP_ADD_IMM, 8'b0010_1???: begin
          sum = {1'b0, acc_reg} + {1'b0, (opc[3] ? rn : b1)};
          acc_next = sum[7:0];
          cy_next = sum[8];
        end
        `OP_CJNE_A_IMM, 8'b1011_011?: begin
          dec = (opc[1] ? ind : acc_reg);
          cy_next = (dec < b1);
          if (dec != b1) begin
            pc_next = rel_tgt(pc_seq, b2);
          end
        end
        `OP_DJNZ_DIR: begin
          dec = dir1 - 8'h01;
          we = 1'b1;
          wa = b1;
          wd = dec;
          if (dec != 8'h00) begin
            pc_next = rel_tgt(pc_seq, b2);
          end
        end
        8'b1101_1???: begin
          dec = rn - 8'h01;
          we = 1'b1;
          wa = {5'h00, opc[2:0]};
          wd = dec;
          if (dec != 8'h00) begin
            pc_next = rel_tgt(pc_seq, b1);
          end
        end
        `OP_JB, `OP_JBC: begin
          if (bit_val) begin
            pc_next = rel_tgt(pc_seq, b2);
            we = (opc == `OP_JBC);
            wa = {1'b0, `BIT_AREA_HI, b1[6:3]};
            wd = bit_byte & ~(8'h01 << b1[2:0]);
          end
        end
        `OP_JC: if (cy_reg) pc_next = rel_tgt(pc_seq, b1);
        `OP_JNC: if (!cy_reg) pc_next = rel_tgt(pc_seq, b1);
        `OP_JZ: if (acc_reg == 8'h00) pc_next = rel_tgt(pc_seq, b1);
        `OP_JNZ: if (acc_reg != 8'h00) pc_next = rel_tgt(pc_seq, b1);
        `OP_SJMP: pc_next = rel_tgt(pc_seq, b1);
        `OP_LJMP: pc_next = {b1, b2};
        `OP_JMP_INDEXED: pc_next = acc_plus_pointer;
        `OP_MOVC_INDEXED: acc_next = code_data;
        `OP_MOVX_WR: begin
          xaddr_next = active_data_pointer;
          xwdata_next = acc_reg;
          xwe_next = 1'b1;
        end
        `OP_MOVX_RD: acc_next = xram_rdata;
        `OP_MOV_POINTER_IMM: begin
          load_pointer = 1'b1;
          pointer_new = {b1, b2};
        end
        `OP_INC_POINTER: begin
          load_pointer = 1'b1;
          pointer_new = active_data_pointer + 16'h0001;
        end
        `OP_PUSH: begin
          sp_next = sp_inc;
          we = 1'b1;
          wa = {1'b0, sp_inc[6:0]};
          wd = dir1;
        end
        `OP_POP: begin
          sp_next = sp_reg - 8'h01;
          we = 1'b1;
          wa = b1;
          wd = stk;
        end
        `OP_MOV_DIR_DIR: begin
          we = 1'b1;
          wa = b2;
          wd = dir1;
        end
        `OP_ANL_DIR_IMM: begin
          we = 1'b1;
          wa = b1;
          wd = dir1 & b2;
        end
        `OP_SWAP: acc_next = {acc_reg[3:0], acc_reg[7:4]};
        `OP_RLC: begin
          acc_next = {acc_reg[6:0], cy_reg};
          cy_next = acc_reg[7];
        end
        `OP_MOV_A_IMM: acc_next = b1;
        `OP_CLR_A: acc_next = 8'h00;
        default: acc_next = acc_reg;
      endcase
    end
    // Loads go to whichever pointer the select input names
    if (load_pointer) begin
      if (data_pointer_select) begin
        d1_next = pointer_new;
      end else begin
        d0_next = pointer_new;
      end
    end
    // Direct writes into the core SFRs
    if (we && wa[7]) begin
      case (wa)
        `SFR_ACC: acc_next = wd;
        `SFR_SP: sp_next = wd;
        `SFR_DPL0: d0_next = {pointer0_reg[15:8], wd};
        `SFR_DPH0: d0_next = {wd, pointer0_reg[7:0]};
        `SFR_DPL1: d1_next = {pointer1_reg[15:8], wd};
        `SFR_DPH1: d1_next = {wd, pointer1_reg[7:0]};
        default: ;
      endcase
    end
  end

  // Internal RAM, lower 128 bytes
  always @(posedge clk) begin
    if (we && !wa[7]) begin
      iram[wa[6:0]] <= wd;
    end
  end

  // Sequencer and architectural state
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 3'd0;
      opc_reg <= `OP_NOP;
      op1_reg <= 8'h00;
      op2_reg <= 8'h00;
      pc_reg <= `RST_PC;
      acc_reg <= 8'h00;
      cy_reg <= 1'b0;
      sp_reg <= `RST_SP;
      pointer0_reg <= `RST_POINTER;
      pointer1_reg <= `RST_POINTER;
      xram_addr_reg <= 16'h0000;
      xram_wdata_reg <= 8'h00;
      xram_we_reg <= 1'b0;
      xram_re_reg <= 1'b0;
      instr_done_reg <= 1'b0;
      last_opcode_reg <= `OP_NOP;
    end else begin
      cnt_reg <= exec ? 3'd0 : cnt_reg + 3'd1;
      opc_reg <= opc;
      if (cnt_reg == 3'd1) begin
        op1_reg <= code_data;
      end
      if (cnt_reg == 3'd2) begin
        op2_reg <= code_data;
      end
      pc_reg <= pc_next;
      acc_reg <= acc_next;
      cy_reg <= cy_next;
      sp_reg <= sp_next;
      pointer0_reg <= d0_next;
      pointer1_reg <= d1_next;
      xram_addr_reg <= xaddr_next;
      xram_wdata_reg <= xwdata_next;
      xram_we_reg <= xwe_next;
      xram_re_reg <= xre_next;
      instr_done_reg <= exec;
      if (exec) begin
        last_opcode_reg <= opc;
      end
    end
  end

endmodule // instr_sequencer

// File: tb/instr_sequencer_monitor.sv
`timescale 1ns/1ps
module instr_sequencer_monitor (
  input wire clk,
  input wire rst_n,
  input wire [15:0] code_addr,
  input wire [7:0] code_data,
  input wire data_pointer_select,
  input wire [15:0] xram_addr_reg,
  input wire [7:0] xram_wdata_reg,
  input wire xram_we_reg,
  input wire xram_re_reg,
  input wire [7:0] xram_rdata,
  input wire [15:0] pc_reg,
  input wire [7:0] acc_reg,
  input wire cy_reg,
  input wire [15:0] pointer0_reg,
  input wire [15:0] pointer1_reg,
  input wire instr_done_reg,
  input wire [7:0] last_opcode_reg
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Opcode fetch cycle marker and active pointer
  wire st = code_addr == pc_reg;
  wire [15:0] dp = data_pointer_select ? pointer1_reg : pointer0_reg;
  reg [7:0] acc_d;
  // Accumulator one cycle back
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      acc_d <= 8'h00;
    else
      acc_d <= acc_reg;
  end
  a_add_imm_time: assert property (st && code_data == 8'h24 |=> !instr_done_reg ##1
    instr_done_reg && pc_reg == $past(pc_reg, 2) + 16'h0002) else $error("add immediate timing");
  a_one_cycle_ops: assert property (st && (code_data == 8'hc4 || code_data == 8'h33 ||
    code_data == 8'hf0 || code_data[7:3] == 5'h05) |=> instr_done_reg && pc_reg == $past(pc_reg) + 16'h0001)
    else $error("single cycle op timing");
  a_carry_branch: assert property (st && (code_data == 8'h40 || code_data == 8'h50) |=>
    !instr_done_reg [*2] ##1 instr_done_reg) else $error("carry branch timing");
  a_cjne_ind_time: assert property (st && code_data[7:1] == 7'h5b |=> !instr_done_reg [*4] ##1
    instr_done_reg && last_opcode_reg[7:1] == 7'h5b) else $error("indirect compare timing");
  a_djnz_dir_time: assert property (st && code_data == 8'hd5 |-> ##5 instr_done_reg &&
    last_opcode_reg == 8'hd5) else $error("direct decrement loop timing");
  a_movc_fetch: assert property (st && code_data == 8'h93 |-> ##4 code_addr == {8'h00, acc_reg} + dp
    ##1 instr_done_reg && acc_reg == $past(code_data)) else $error("code read wrong");
  a_jmp_target: assert property (st && code_data == 8'h73 |-> ##5 instr_done_reg &&
    pc_reg == {8'h00, acc_reg} + dp) else $error("indirect jump wrong");
  a_write_strobe: assert property (xram_we_reg |-> instr_done_reg && last_opcode_reg == 8'hf0 &&
    xram_wdata_reg == acc_reg && xram_addr_reg == dp) else $error("external write wrong");
  a_read_result: assert property (xram_re_reg |-> $past(code_data) == 8'he0 ##1 instr_done_reg &&
    acc_reg == $past(xram_rdata)) else $error("external read wrong");
  a_swap_nibbles: assert property (instr_done_reg && last_opcode_reg == 8'hc4 |->
    acc_reg == {acc_d[3:0], acc_d[7:4]}) else $error("nibble swap wrong");
endmodule // instr_sequencer_monitor

// File: tb/pipelined_mcu_instruction_timing_tb.sv
`timescale 1ns/1ps
module pipelined_mcu_instruction_timing_tb;
  typedef struct {logic [7:0] op; logic [15:0] pc; logic [7:0] a; logic c; logic [15:0] d0; logic [15:0] d1;
    int cyc;} note_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic data_pointer_select = 1'b0;
  logic [7:0] rom [0:255];
  logic [31:0] seed = 32'd27230;
  logic [15:0] pc, d0, d1, jt;
  logic [7:0] a, r3, m;
  logic c;
  int error_cnt = 0;
  int samples_checked = 0;
  note_t q[$];
  wire [15:0] code_addr, xram_addr_reg, pc_reg, pointer0_reg, pointer1_reg;
  wire [7:0] xram_wdata_reg, acc_reg, last_opcode_reg;
  wire xram_we_reg, xram_re_reg, cy_reg, instr_done_reg;
  // Program memory and external memory answer combinationally
  wire [7:0] code_data = rom[code_addr[7:0]];
  wire [7:0] xram_rdata = xram_addr_reg[15:8] ^ xram_addr_reg[7:0] ^ 8'h5a;

  instr_sequencer uut (.clk, .rst_n, .code_addr, .code_data, .data_pointer_select, .xram_addr_reg,
    .xram_wdata_reg, .xram_we_reg, .xram_re_reg, .xram_rdata, .pc_reg, .acc_reg, .cy_reg, .pointer0_reg,
    .pointer1_reg, .instr_done_reg, .last_opcode_reg);

  always #50 clk = ~clk;

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Place one instruction and note its expected outcome
  task automatic put(input logic [7:0] op, b1, b2, input int len, cyc, tk);
    note_t n;
    rom[pc[7:0]] = op;
    rom[pc[7:0] + 8'h01] = b1;
    rom[pc[7:0] + 8'h02] = b2;
    pc = (tk == 2) ? jt : pc + 16'(len) + ((tk != 0) ? 16'h0003 : 16'h0000);
    n = '{op, pc, a, c, d0, d1, cyc};
    q.push_back(n);
  endtask

  // One program run with a given pointer select
  task automatic run(input logic s);
    logic [7:0] k, v, h, l;
    rst_n = 1'b0;
    @(negedge clk);
    data_pointer_select = s;
    for (int i = 0; i < 256; i++)
      rom[i] = 8'h00;
    pc = 16'h0000;
    d0 = 16'h0000;
    d1 = 16'h0000;
    c = 1'b0;
    k = rnd();
    a = k;
    put(8'h74, k, 0, 2, 2, 0);
    v = rnd();
    {c, a} = a + v;
    put(8'h24, v, 0, 2, 2, 0);
    put(8'hc0, 8'he0, 0, 2, 3, 0);
    r3 = a;
    put(8'hd0, 8'h03, 0, 2, 2, 0);
    {c, a} = a + r3;
    put(8'h2b, 0, 0, 1, 1, 0);
    a = {a[3:0], a[7:4]};
    put(8'hc4, 0, 0, 1, 1, 0);
    {c, a} = {a, c};
    put(8'h33, 0, 0, 1, 1, 0);
    put(8'h40, 8'h03, 0, 2, 3, c);
    put(8'h50, 8'h03, 0, 2, 3, !c);
    put(8'h60, 8'h03, 0, 2, 4, a == 0);
    put(8'h70, 8'h03, 0, 2, 4, a != 0);
    for (int i = 0; i < 2; i++) begin
      v = (i != 0) ? rnd() : a;
      c = a < v;
      put(8'hb4, v, 8'h03, 3, 4, a != v);
    end
    r3 = r3 - 8'h01;
    put(8'hdb, 8'h03, 0, 2, 4, r3 != 0);
    r3 = r3 - 8'h01;
    put(8'hd5, 8'h03, 8'h03, 3, 5, r3 != 0);
    m = a;
    put(8'h85, 8'he0, 8'h20, 3, 3, 0);
    v = rnd();
    m = m & v;
    put(8'h53, 8'h20, v, 3, 3, 0);
    for (int b = 0; b < 8; b++)
      put(8'h20, b, 8'h03, 3, 5, m[b]);
    v = rnd() & 8'h07;
    put(8'h10, v, 8'h03, 3, 5, m[v[2:0]]);
    m[v[2:0]] = 1'b0;
    a = m;
    put(8'h85, 8'h20, 8'he0, 3, 3, 0);
    a = 8'h20;
    put(8'h74, 8'h20, 0, 2, 2, 0);
    for (int i = 0; i < 2; i++) begin
      put(8'hc0, 8'he0, 0, 2, 3, 0);
      put(8'hd0, 8'(i), 0, 2, 2, 0);
      v = (i != 0) ? rnd() : m;
      c = m < v;
      put(8'hb6 + 8'(i), v, 8'h03, 3, 5, m != v);
    end
    h = rnd();
    l = rnd();
    if (s)
      d1 = {h, l};
    else
      d0 = {h, l};
    put(8'h90, h, l, 3, 3, 0);
    put(8'hf0, 0, 0, 1, 1, 0);
    a = h ^ l ^ 8'h5a;
    put(8'he0, 0, 0, 1, 2, 0);
    a = 8'h01 - l;
    put(8'h74, a, 0, 2, 2, 0);
    a = k;
    put(8'h93, 0, 0, 1, 5, 0);
    a = pc[7:0] + 8'h07 - l;
    jt = {h, l} + {8'h00, a};
    put(8'h74, a, 0, 2, 2, 0);
    put(8'h73, 0, 0, 1, 5, 2);
    v = rnd();
    {c, a} = a + v;
    put(8'h24, v, 0, 2, 2, 0);
    if (s)
      d1 = d1 + 16'h0001;
    else
      d0 = d0 + 16'h0001;
    put(8'ha3, 0, 0, 1, 1, 0);
    a = 8'h00;
    put(8'he4, 0, 0, 1, 1, 0);
    put(8'h00, 0, 0, 1, 1, 0);
    put(8'h80, 8'h03, 0, 2, 3, 1);
    jt = pc + 16'h0010;
    put(8'h02, jt[15:8], jt[7:0], 3, 4, 2);
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    for (int t = 0; t < 2000 && q.size() > 0; t++)
      @(negedge clk);
    chk(q.size(), 0);
  endtask

  // Output watcher: one note per completed instruction
  initial begin
    note_t n;
    int cnt;
    cnt = 0;
    forever begin
      @(negedge clk);
      cnt++;
      if (!rst_n)
        cnt = -100;
      else if (instr_done_reg === 1'b1 && q.size() > 0) begin
        n = q.pop_front();
        chk(last_opcode_reg, n.op);
        chk(pc_reg, n.pc);
        chk(acc_reg, n.a);
        chk(cy_reg, n.c);
        chk(pointer0_reg, n.d0);
        chk(pointer1_reg, n.d1);
        if (cnt > 0)
          chk(cnt, n.cyc);
        if (n.op == 8'hf0) begin
          chk(xram_we_reg, 1);
          chk(xram_addr_reg, data_pointer_select ? n.d1 : n.d0);
          chk(xram_wdata_reg, n.a);
        end
        cnt = 0;
      end
    end
  end

  // Main sequence
  initial begin
    run(1'b0);
    run(1'b1);
    test_done();
  end

  // Hang guard
  initial begin
    #500000;
    error_cnt++;
    test_done();
  end
endmodule // pipelined_mcu_instruction_timing_tb

bind instr_sequencer instr_sequencer_monitor mon (.clk, .rst_n, .code_addr, .code_data, .data_pointer_select,
  .xram_addr_reg, .xram_wdata_reg, .xram_we_reg, .xram_re_reg, .xram_rdata, .pc_reg, .acc_reg, .cy_reg,
  .pointer0_reg, .pointer1_reg, .instr_done_reg, .last_opcode_reg);
